//--- pkg/dio_map_pkg.sv
// Constants and types shared by the terminal mapping logic.
//
// Behaviour
// - Each input and output terminal is assigned a function by its own selector.
// - Factory defaults: inputs a=2, b=11, c,d=0; outputs one=2, two=9.
// - A terminal change reaches its function between 8 ms and 16 ms later.
// - Polarity bit 0 inverts output_one, bit 1 inverts output_two.
// - Seven internal input functions are offered to the input terminals.
// - Torque cap select is a level: low limit 1, high limit 2.
// - Speed cap select is a level: low limit 1, high limit 2.
// - Emergency halt input low commands a stop; high allows ready to run.
// - A rising edge on home point set is the reference or cam event.
// - Positive travel limit held high; a falling edge triggers quick stop.
// - Negative travel limit held high; a falling edge triggers quick stop.
// - Nine internal status flags are offered to the output terminals.
// - Drive ok high when ready; fault flag high while in fault.
// - Standstill high at or below threshold; low above threshold plus 10 rpm.
// - Torque at limit high when torque is near any torque limit.
// - Brake state high when brake closed; status only.
// - Overload high when output reaches threshold percent, default 100, max 300.
// - Can switch on low on fault, no mains, or control bits 1,2 not set.
// - In position high while following error lies inside the window.
package dio_map_pkg;
   localparam int unsigned CLK_HZ = 20000000;
   localparam int unsigned RESP_MIN_MS = 8;
   localparam int unsigned RESP_MAX_MS = 16;
   // Input must be stable this long; sync latency plus this stays within max.
   localparam int unsigned FILTER_CYCLES = CLK_HZ / 1000 * RESP_MIN_MS;
   localparam int unsigned RESP_MAX_CYCLES = CLK_HZ / 1000 * RESP_MAX_MS;
   localparam int unsigned STANDSTILL_HYST_RPM = 10;
   localparam int unsigned OVERLOAD_DEFAULT_PCT = 100;
   localparam int unsigned OVERLOAD_MAX_PCT = 300;
   localparam int unsigned IN_COUNT = 4;
   localparam int unsigned OUT_COUNT = 2;
   localparam int unsigned IN_FUNC_COUNT = 7;
   localparam int unsigned OUT_FLAG_COUNT = 9;
   localparam int unsigned POL_BIT_ONE = 0;
   localparam int unsigned POL_BIT_TWO = 1;
   localparam int unsigned STW_BIT_A = 1;
   localparam int unsigned STW_BIT_B = 2;

   typedef logic [4:0] sel_t;

   // Input function codes.
   localparam sel_t IN_NONE = 5'h00;
   localparam sel_t IN_ALARM_RESET = 5'h02;
   localparam sel_t IN_TORQUE_CAP = 5'h0b;
   localparam sel_t IN_SPEED_CAP = 5'h0c;
   localparam sel_t IN_EMERG_HALT = 5'h0d;
   localparam sel_t IN_HOME_SET = 5'h0e;
   localparam sel_t IN_POS_LIMIT = 5'h0f;
   localparam sel_t IN_NEG_LIMIT = 5'h10;

   // Output flag codes.
   localparam sel_t OUT_DRIVE_OK = 5'h01;
   localparam sel_t OUT_FAULT = 5'h02;
   localparam sel_t OUT_STANDSTILL = 5'h03;
   localparam sel_t OUT_TORQUE_LIM = 5'h04;
   localparam sel_t OUT_BRAKE = 5'h05;
   localparam sel_t OUT_OVERLOAD = 5'h09;
   localparam sel_t OUT_SWITCH_ON = 5'h0a;
   localparam sel_t OUT_IN_POS = 5'h0b;
   localparam sel_t OUT_HOMED = 5'h0c;

   // Factory reset values of the selectors.
   localparam sel_t RST_SEL_A = IN_ALARM_RESET;
   localparam sel_t RST_SEL_B = IN_TORQUE_CAP;
   localparam sel_t RST_SEL_C = IN_NONE;
   localparam sel_t RST_SEL_D = IN_NONE;
   localparam sel_t RST_SEL_ONE = OUT_FAULT;
   localparam sel_t RST_SEL_TWO = OUT_OVERLOAD;
   localparam logic [1:0] RST_POLARITY = 2'h0;
endpackage : dio_map_pkg

//--- rtl/input_filter.sv
// Three-stage synchroniser and stability filter for one terminal.
`timescale 1ns/100ps
module input_filter #(
   parameter int unsigned STABLE_CYCLES = dio_map_pkg::FILTER_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic pin_in,
   output logic level_out,
   output logic rise_pulse,
   output logic fall_pulse
);
   import dio_map_pkg::*;

   localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);

   initial begin
      if (STABLE_CYCLES < 1) begin
         $error("input_filter: STABLE_CYCLES must be at least one");
      end
   end

   typedef struct packed {
      logic [2:0] sync;
      logic [CW-1:0] cnt;
      logic level;
      logic rise;
      logic fall;
   } filt_state_t;

   filt_state_t st_q;
   filt_state_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.rise = 1'b0;
      st_d.fall = 1'b0;
      st_d.sync = {st_q.sync[1:0], pin_in};
      // Stages 2 and 3 agreeing count as the synchronised value.
      if (st_q.sync[2] != st_q.sync[1] || st_q.sync[2] == st_q.level) begin
         st_d.cnt = '0;
      end else if (st_q.cnt == CW'(STABLE_CYCLES - 1)) begin
         st_d.cnt = '0;
         st_d.level = st_q.sync[2];
         st_d.rise = st_q.sync[2];
         st_d.fall = ~st_q.sync[2];
      end else begin
         st_d.cnt = st_q.cnt + CW'(1);
      end
   end

   // Reset level is high so a held limit or halt input raises no false edge.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= '{sync: 3'h7, cnt: '0, level: 1'b1, rise: 1'b0, fall: 1'b0};
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   assign level_out = st_q.level;
   assign rise_pulse = st_q.rise & clk_en;
   assign fall_pulse = st_q.fall & clk_en;
endmodule : input_filter

//--- rtl/servo_dio_signal_mapper.sv
// Assignable input and output terminal mapping for a servo drive.
`timescale 1ns/100ps
module servo_dio_signal_mapper #(
   parameter int unsigned FILTER_LEN = dio_map_pkg::FILTER_CYCLES,
   parameter int unsigned SPEED_W = 16,
   parameter int unsigned ERR_W = 24
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic input_terminal_a,
   input wire logic input_terminal_b,
   input wire logic input_terminal_c,
   input wire logic input_terminal_d,
   output logic output_one,
   output logic output_two,
   input wire dio_map_pkg::sel_t input_map_sel_a,
   input wire dio_map_pkg::sel_t input_map_sel_b,
   input wire dio_map_pkg::sel_t input_map_sel_c,
   input wire dio_map_pkg::sel_t input_map_sel_d,
   input wire dio_map_pkg::sel_t output_map_sel_one,
   input wire dio_map_pkg::sel_t output_map_sel_two,
   input wire logic [1:0] output_polarity_sel,
   input wire logic cfg_load,
   input wire logic control_mode_pos,
   input wire logic ready_to_run,
   input wire logic alarm_present,
   input wire logic enable_present,
   input wire logic fault_present,
   input wire logic [SPEED_W-1:0] motor_speed_rpm,
   input wire logic [SPEED_W-1:0] zero_speed_threshold,
   input wire logic torque_near_limit,
   input wire logic brake_closed,
   input wire logic [8:0] output_load_pct,
   input wire logic [8:0] overload_threshold,
   input wire logic main_power_ok,
   input wire logic [15:0] control_word,
   input wire logic servo_on,
   input wire logic [ERR_W-1:0] following_error_abs,
   input wire logic [ERR_W-1:0] in_position_window,
   input wire logic referenced,
   input wire logic reference_mode,
   output logic alarm_reset_pulse,
   output logic torque_cap_select,
   output logic speed_cap_select,
   output logic emergency_halt_input,
   output logic home_point_set_pulse,
   output logic reference_cam_pulse,
   output logic positive_travel_limit,
   output logic negative_travel_limit,
   output logic quick_stop_ramp,
   output logic drive_ok_flag,
   output logic fault_flag,
   output logic standstill_flag,
   output logic torque_at_limit_flag,
   output logic brake_state_flag,
   output logic overload_flag,
   output logic can_switch_on_flag,
   output logic in_position_flag,
   output logic homed_flag
);
   import dio_map_pkg::*;

   initial begin
      if (FILTER_LEN < 1 || SPEED_W < 8 || ERR_W < 1) begin
         $error("servo_dio_signal_mapper: unsupported parameter value");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Selection decoding.

   // Position-only functions are refused outside position control.
   function automatic logic in_sel_ok(input sel_t s, input logic pos);
      case (s)
         IN_ALARM_RESET, IN_TORQUE_CAP, IN_SPEED_CAP, IN_EMERG_HALT,
         IN_POS_LIMIT, IN_NEG_LIMIT: in_sel_ok = 1'b1;
         IN_HOME_SET: in_sel_ok = pos;
         default: in_sel_ok = 1'b0;
      endcase
   endfunction : in_sel_ok

   function automatic logic out_sel_ok(input sel_t s, input logic pos);
      case (s)
         OUT_DRIVE_OK, OUT_FAULT, OUT_STANDSTILL, OUT_TORQUE_LIM, OUT_BRAKE,
         OUT_OVERLOAD, OUT_SWITCH_ON: out_sel_ok = 1'b1;
         OUT_IN_POS, OUT_HOMED: out_sel_ok = pos;
         default: out_sel_ok = 1'b0;
      endcase
   endfunction : out_sel_ok

   ////////////////////////////////////////////////////////////////////////
   // Input terminals.

   logic [IN_COUNT-1:0] pins;
   logic [IN_COUNT-1:0] lvl;
   logic [IN_COUNT-1:0] rise;
   logic [IN_COUNT-1:0] fall;

   assign pins = {input_terminal_d, input_terminal_c,
                  input_terminal_b, input_terminal_a};

   genvar gi;
   generate
      for (gi = 0; gi < IN_COUNT; gi++) begin : g_in
         input_filter #(
            .STABLE_CYCLES(FILTER_LEN)
         ) u_filt (
            .core_clk(core_clk),
            .rst(rst),
            .clk_en(clk_en),
            .pin_in(pins[gi]),
            .level_out(lvl[gi]),
            .rise_pulse(rise[gi]),
            .fall_pulse(fall[gi])
         );
      end
   endgenerate

   typedef struct packed {
      sel_t [IN_COUNT-1:0] in_sel;
      sel_t [OUT_COUNT-1:0] out_sel;
      logic [1:0] pol;
      logic standstill;
      logic switch_on_latched;
      logic torque_cap;
      logic speed_cap;
      logic halt;
      logic pos_lim;
      logic neg_lim;
      logic alarm_rst;
      logic home_set;
      logic ref_cam;
      logic quick_stop;
      logic [OUT_COUNT-1:0] dout;
      logic [OUT_FLAG_COUNT-1:0] flags;
   } map_state_t;

   map_state_t st_q;
   map_state_t st_d;

   logic [OUT_FLAG_COUNT-1:0] flags_now;
   logic [SPEED_W:0] speed_release;
   logic switch_on_cond;

   always_comb begin
      speed_release = {1'b0, zero_speed_threshold} +
                      (SPEED_W + 1)'(STANDSTILL_HYST_RPM);
      switch_on_cond = ~fault_present & main_power_ok &
                       control_word[STW_BIT_A] & control_word[STW_BIT_B];
   end

   // Functions that no terminal drives rest at their permissive level.
   always_comb begin
      st_d = st_q;
      st_d.alarm_rst = 1'b0;
      st_d.home_set = 1'b0;
      st_d.ref_cam = 1'b0;
      st_d.quick_stop = 1'b0;
      st_d.torque_cap = 1'b0;
      st_d.speed_cap = 1'b0;
      st_d.halt = 1'b1;
      st_d.pos_lim = 1'b1;
      st_d.neg_lim = 1'b1;
      if (cfg_load) begin
         st_d.in_sel = {input_map_sel_d, input_map_sel_c,
                        input_map_sel_b, input_map_sel_a};
         st_d.out_sel = {output_map_sel_two, output_map_sel_one};
         st_d.pol = output_polarity_sel;
      end
      for (int i = 0; i < IN_COUNT; i++) begin
         if (in_sel_ok(st_q.in_sel[i], control_mode_pos)) begin
            case (st_q.in_sel[i])
               IN_ALARM_RESET: st_d.alarm_rst = st_d.alarm_rst | rise[i];
               IN_TORQUE_CAP: st_d.torque_cap = st_d.torque_cap | lvl[i];
               IN_SPEED_CAP: st_d.speed_cap = st_d.speed_cap | lvl[i];
               IN_EMERG_HALT: st_d.halt = st_d.halt & lvl[i];
               IN_HOME_SET: begin
                  st_d.home_set = st_d.home_set |
                                  (rise[i] & ~reference_mode);
                  st_d.ref_cam = st_d.ref_cam |
                                 (rise[i] & reference_mode);
               end
               IN_POS_LIMIT: begin
                  st_d.pos_lim = st_d.pos_lim & lvl[i];
                  st_d.quick_stop = st_d.quick_stop | fall[i];
               end
               IN_NEG_LIMIT: begin
                  st_d.neg_lim = st_d.neg_lim & lvl[i];
                  st_d.quick_stop = st_d.quick_stop | fall[i];
               end
               default: ;
            endcase
         end
      end

      // Standstill holds between threshold and threshold plus hysteresis.
      if (motor_speed_rpm <= zero_speed_threshold) begin
         st_d.standstill = 1'b1;
      end else if ({1'b0, motor_speed_rpm} > speed_release) begin
         st_d.standstill = 1'b0;
      end

      if (!switch_on_cond) begin
         st_d.switch_on_latched = 1'b0;
      end else if (servo_on) begin
         st_d.switch_on_latched = 1'b1;
      end

      flags_now = '0;
      flags_now[0] = ready_to_run & ~alarm_present & enable_present;
      flags_now[1] = fault_present;
      flags_now[2] = st_q.standstill;
      flags_now[3] = torque_near_limit;
      flags_now[4] = brake_closed;
      flags_now[5] = output_load_pct >= overload_threshold;
      // The freshly updated latch is used so a lost condition drops at once.
      flags_now[6] = switch_on_cond | st_d.switch_on_latched;
      flags_now[7] = following_error_abs <= in_position_window;
      flags_now[8] = referenced;
      st_d.flags = flags_now;

      for (int o = 0; o < OUT_COUNT; o++) begin
         st_d.dout[o] = st_q.pol[o];
         if (out_sel_ok(st_q.out_sel[o], control_mode_pos)) begin
            case (st_q.out_sel[o])
               OUT_DRIVE_OK: st_d.dout[o] = flags_now[0] ^ st_q.pol[o];
               OUT_FAULT: st_d.dout[o] = flags_now[1] ^ st_q.pol[o];
               OUT_STANDSTILL: st_d.dout[o] = flags_now[2] ^ st_q.pol[o];
               OUT_TORQUE_LIM: st_d.dout[o] = flags_now[3] ^ st_q.pol[o];
               OUT_BRAKE: st_d.dout[o] = flags_now[4] ^ st_q.pol[o];
               OUT_OVERLOAD: st_d.dout[o] = flags_now[5] ^ st_q.pol[o];
               OUT_SWITCH_ON: st_d.dout[o] = flags_now[6] ^ st_q.pol[o];
               OUT_IN_POS: st_d.dout[o] = flags_now[7] ^ st_q.pol[o];
               OUT_HOMED: st_d.dout[o] = flags_now[8] ^ st_q.pol[o];
               default: st_d.dout[o] = st_q.pol[o];
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= '0;
         st_q.in_sel <= {RST_SEL_D, RST_SEL_C, RST_SEL_B, RST_SEL_A};
         st_q.out_sel <= {RST_SEL_TWO, RST_SEL_ONE};
         st_q.pol <= RST_POLARITY;
         st_q.halt <= 1'b1;
         st_q.pos_lim <= 1'b1;
         st_q.neg_lim <= 1'b1;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   // Pulses are gated so a frozen block never repeats an event.
   assign alarm_reset_pulse = st_q.alarm_rst & clk_en;
   assign home_point_set_pulse = st_q.home_set & clk_en;
   assign reference_cam_pulse = st_q.ref_cam & clk_en;
   assign quick_stop_ramp = st_q.quick_stop & clk_en;
   assign torque_cap_select = st_q.torque_cap;
   assign speed_cap_select = st_q.speed_cap;
   assign emergency_halt_input = st_q.halt;
   assign positive_travel_limit = st_q.pos_lim;
   assign negative_travel_limit = st_q.neg_lim;
   assign output_one = st_q.dout[0];
   assign output_two = st_q.dout[1];
   assign drive_ok_flag = st_q.flags[0];
   assign fault_flag = st_q.flags[1];
   assign standstill_flag = st_q.flags[2];
   assign torque_at_limit_flag = st_q.flags[3];
   assign brake_state_flag = st_q.flags[4];
   assign overload_flag = st_q.flags[5];
   assign can_switch_on_flag = st_q.flags[6];
   assign in_position_flag = st_q.flags[7];
   assign homed_flag = st_q.flags[8];
endmodule : servo_dio_signal_mapper

//--- tb/dio_map_chk.sv
// Port-level assertions for the terminal mapper.
`timescale 1ns/100ps
module dio_map_chk
   import dio_map_pkg::*;
#(
   parameter int unsigned SPEED_W = 16
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ready_to_run,
   input wire logic alarm_present,
   input wire logic enable_present,
   input wire logic fault_present,
   input wire logic [SPEED_W-1:0] motor_speed_rpm,
   input wire logic [SPEED_W-1:0] zero_speed_threshold,
   input wire logic brake_closed,
   input wire logic [8:0] output_load_pct,
   input wire logic [8:0] overload_threshold,
   input wire logic main_power_ok,
   input wire logic [15:0] control_word,
   input wire logic alarm_reset_pulse,
   input wire logic positive_travel_limit,
   input wire logic negative_travel_limit,
   input wire logic quick_stop_ramp,
   input wire logic drive_ok_flag,
   input wire logic fault_flag,
   input wire logic standstill_flag,
   input wire logic brake_state_flag,
   input wire logic overload_flag,
   input wire logic can_switch_on_flag
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // The $past(rst) guards skip the first edge, where flags still hold reset.
   a_fault_flag: assert property (
      !$past(rst) |-> fault_flag == $past(fault_present))
      else $error("fault flag does not follow its source");
   a_ready_flag: assert property (
      !$past(rst) |-> drive_ok_flag == ($past(ready_to_run) &&
      !$past(alarm_present) && $past(enable_present)))
      else $error("drive ok flag wrong");
   a_overload_lvl: assert property (
      !$past(rst) |-> overload_flag ==
      ($past(output_load_pct) >= $past(overload_threshold)))
      else $error("overload flag wrong");
   a_switch_block: assert property (
      !main_power_ok || fault_present || control_word[2:1] != 2'h3
      |=> !can_switch_on_flag) else $error("switch on flag set wrongly");
   a_still_set: assert property (
      motor_speed_rpm <= zero_speed_threshold |-> ##2 standstill_flag)
      else $error("standstill flag not set");
   a_still_clear: assert property (
      motor_speed_rpm > zero_speed_threshold + STANDSTILL_HYST_RPM
      |-> ##2 !standstill_flag) else $error("standstill flag not cleared");
   a_brake_lvl: assert property (
      !$past(rst) |-> brake_state_flag == $past(brake_closed))
      else $error("brake flag wrong");
   a_alarm_once: assert property (
      alarm_reset_pulse |=> !alarm_reset_pulse)
      else $error("alarm reset pulse too long");
   a_limit_stop: assert property (
      $fell(positive_travel_limit) || $fell(negative_travel_limit)
      |-> quick_stop_ramp) else $error("no quick stop on limit fall");
endmodule : dio_map_chk

//--- tb/field_switches.sv
// Field switch model driving the four input terminals.
`timescale 1ns/100ps
module field_switches (
   input wire logic core_clk,
   output logic [3:0] pins
);
   // Limit terminals sit high so that the drive may run.
   initial pins = 4'hf;
   // A real contact bounces, so three cycles of the new level are followed by a one-cycle blip of the opposite level.
   task automatic move(input int idx, input logic lvl);
      repeat (3) @(negedge core_clk) pins[idx] = lvl;
      @(negedge core_clk) pins[idx] = !lvl;
      @(negedge core_clk) pins[idx] = lvl;
   endtask : move
endmodule : field_switches

//--- tb/testbench.sv
// Self-checking bench for the terminal mapper.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   n_fail++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
bind servo_dio_signal_mapper dio_map_chk #(.SPEED_W(SPEED_W)) chk (.*);
module testbench;
   import dio_map_pkg::*;
   localparam int unsigned FL = 8;
   typedef struct {logic [3:0] vec; int t0;} note_t;
   note_t notes[$];
   int cyc = 0, n_fail = 0, num_checks = 0, seed = 41051;
   logic core_clk, rst, cfg_load, ready_to_run, alarm_present, enable_present;
   logic fault_present, torque_near_limit, brake_closed, main_power_ok;
   logic servo_on, referenced, reference_mode;
   logic clk_en = 1'b1, control_mode_pos = 1'b1;
   logic [15:0] motor_speed_rpm, zero_speed_threshold, control_word;
   logic [8:0] output_load_pct, overload_threshold;
   logic [23:0] following_error_abs, in_position_window;
   sel_t input_map_sel_a, input_map_sel_b, input_map_sel_c, input_map_sel_d;
   sel_t output_map_sel_one, output_map_sel_two, c;
   logic [1:0] output_polarity_sel;
   logic [3:0] pins, e;
   logic output_one, output_two, alarm_reset_pulse, torque_cap_select;
   logic speed_cap_select, emergency_halt_input, home_point_set_pulse;
   logic reference_cam_pulse, positive_travel_limit, negative_travel_limit;
   logic quick_stop_ramp, drive_ok_flag, fault_flag, standstill_flag;
   logic torque_at_limit_flag, brake_state_flag, overload_flag;
   logic can_switch_on_flag, in_position_flag, homed_flag;
   wire [3:0] pv = {alarm_reset_pulse, home_point_set_pulse,
      reference_cam_pulse, quick_stop_ramp};
   sel_t icode[8] = '{IN_ALARM_RESET, IN_TORQUE_CAP, IN_SPEED_CAP,
      IN_EMERG_HALT, IN_HOME_SET, IN_HOME_SET, IN_POS_LIMIT, IN_NEG_LIMIT};
   sel_t ocode[10] = '{OUT_DRIVE_OK, OUT_FAULT, OUT_STANDSTILL, OUT_TORQUE_LIM,
      OUT_BRAKE, OUT_OVERLOAD, OUT_SWITCH_ON, OUT_IN_POS, OUT_HOMED, IN_NONE};

   servo_dio_signal_mapper #(.FILTER_LEN(FL)) dut (.*,
      .input_terminal_a(pins[0]), .input_terminal_b(pins[1]),
      .input_terminal_c(pins[2]), .input_terminal_d(pins[3]));
   field_switches sw (.core_clk(core_clk), .pins(pins));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////////////////////
   // Each pulse takes the oldest note; a pulse with no note fails.
   always @(negedge core_clk) begin
      note_t n;
      if (|pv) begin
         if (notes.size()) n = notes.pop_front();
         else n = '{4'h0, cyc};
         `CHK("pulse", n.vec, pv)
         `CHK("delay", 1'b1, cyc - n.t0 >= FL && cyc - n.t0 <= 2 * FL)
      end
   end

   task automatic setrnd();
      {ready_to_run, alarm_present, enable_present, fault_present,
         torque_near_limit, brake_closed, main_power_ok, servo_on,
         referenced} = 9'($random(seed));
      control_word = 16'($random(seed));
      zero_speed_threshold = 16'h0014;
      // Speeds stay clear of the hysteresis band so the level is settled.
      motor_speed_rpm = ($random(seed) % 2) ? 16'h0064 : 16'h0000;
      output_load_pct = 9'($random(seed));
      overload_threshold = 9'($unsigned($random(seed)) % 301);
      following_error_abs = 24'($unsigned($random(seed)) % 16);
      in_position_window = 24'($unsigned($random(seed)) % 16);
   endtask : setrnd

   function automatic logic flag(input sel_t s);
      case (s)
         OUT_DRIVE_OK: return ready_to_run & !alarm_present & enable_present;
         OUT_FAULT: return fault_present;
         OUT_STANDSTILL: return motor_speed_rpm <= zero_speed_threshold;
         OUT_TORQUE_LIM: return torque_near_limit;
         OUT_BRAKE: return brake_closed;
         OUT_OVERLOAD: return output_load_pct >= overload_threshold;
         OUT_SWITCH_ON: return !fault_present && main_power_ok &&
            control_word[2:1] == 2'h3;
         OUT_IN_POS: return control_mode_pos &&
            following_error_abs <= in_position_window;
         OUT_HOMED: return control_mode_pos && referenced;
         default: return 1'b0;
      endcase
   endfunction : flag

   task automatic load_cfg();
      @(negedge core_clk) cfg_load = 1'b1;
      @(negedge core_clk) cfg_load = 1'b0;
      repeat (2) @(negedge core_clk);
   endtask : load_cfg

   task automatic toggle(input int idx, input int v, input logic [3:0] ev);
      sw.move(idx, v[0]);
      if (|ev) notes.push_back('{ev, cyc});
      repeat (2 * FL + 4) @(negedge core_clk);
   endtask : toggle

   task automatic check_outs();
      repeat (4) begin
         setrnd();
         repeat (3) @(negedge core_clk);
         `CHK("out_one", flag(output_map_sel_one) ^ output_polarity_sel[0],
            output_one)
         `CHK("out_two", flag(output_map_sel_two) ^ output_polarity_sel[1],
            output_two)
         `CHK("flags", {torque_near_limit, referenced,
            following_error_abs <= in_position_window,
            flag(OUT_SWITCH_ON)}, {torque_at_limit_flag, homed_flag,
            in_position_flag, can_switch_on_flag})
      end
   endtask : check_outs

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      cfg_load = 1'b0;
      reference_mode = 1'b0;
      {input_map_sel_a, input_map_sel_b, input_map_sel_c} = 15'h0000;
      {input_map_sel_d, output_map_sel_one, output_map_sel_two} = 15'h0000;
      output_polarity_sel = 2'h0;
      setrnd();
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      repeat (2 * FL + 4) @(negedge core_clk);
      `CHK("tcap_dflt", 1'b1, torque_cap_select)
      output_map_sel_one = OUT_FAULT;
      output_map_sel_two = OUT_OVERLOAD;
      check_outs();
      toggle(0, 0, 4'h0);
      toggle(0, 1, 4'h8);
      for (int i = 0; i < 8; i++) begin
         c = icode[i];
         input_map_sel_c = c;
         reference_mode = (i == 5);
         load_cfg();
         for (int v = 0; v < 2; v++) begin
            e = {v == 1 && c == IN_ALARM_RESET,
               v == 1 && c == IN_HOME_SET && !reference_mode,
               v == 1 && c == IN_HOME_SET && reference_mode,
               v == 0 && (c == IN_POS_LIMIT || c == IN_NEG_LIMIT)};
            toggle(2, v, e);
            `CHK("levels", {c == IN_TORQUE_CAP && v, c == IN_SPEED_CAP && v,
               c != IN_EMERG_HALT || v, c != IN_POS_LIMIT || v,
               c != IN_NEG_LIMIT || v}, {torque_cap_select, speed_cap_select,
               emergency_halt_input, positive_travel_limit,
               negative_travel_limit})
         end
      end
      foreach (ocode[k]) for (int p = 0; p < 4; p++) begin
         output_map_sel_one = ocode[k];
         output_map_sel_two = ocode[(k + 3) % 10];
         output_polarity_sel = 2'(p);
         control_mode_pos = (p != 2);
         load_cfg();
         check_outs();
      end
      `CHK("pending", 0, notes.size())
      finish_test();
   end

   // The sequence needs about 1,160 cycles; allow ample margin.
   initial begin
      repeat (6000) @(posedge core_clk);
      n_fail++;
      finish_test();
   end
endmodule : testbench
